// [dcf_pkg.sv]
package dcf_pkg;

    // ------------------------------------------------------------
    // selections
    // ------------------------------------------------------------
    localparam logic [1:0] DEC_64 = 2'h0;
    localparam logic [1:0] DEC_128 = 2'h1;
    localparam logic [1:0] DEC_256 = 2'h2;
    localparam logic [1:0] DIV_NORMAL_LAST = 2'h1;
    localparam logic [1:0] DIV_LOW_LAST = 2'h3;
    localparam logic [2:0] ST1_LOG2 = 3'h2;
    localparam logic [2:0] ST2_LOG2_BASE = 3'h3;
    localparam logic [2:0] ST3_LOG2 = 3'h1;
    localparam logic [2:0] OSR_LOG2_BASE = 3'h6;
    localparam logic [3:0] OSR_LOG2_MAX = 4'h8;
    localparam logic [15:0] ODR_PERIOD_64 = 16'h0080;

    // ------------------------------------------------------------
    // delays in master clock periods; coarse group delay in word periods
    // ------------------------------------------------------------
    localparam logic [15:0] OFFSET_NP_64 = 16'd87;
    localparam logic [15:0] OFFSET_NP_128 = 16'd141;
    localparam logic [15:0] OFFSET_NP_256 = 16'd252;
    localparam logic [15:0] OFFSET_LP_64 = 16'd113;
    localparam logic [15:0] OFFSET_LP_128 = 16'd167;
    localparam logic [15:0] OFFSET_LP_256 = 16'd277;
    localparam logic [15:0] COMP_NP_64 = 16'd80;
    localparam logic [15:0] COMP_NP_128 = 16'd113;
    localparam logic [15:0] COMP_NP_256 = 16'd443;
    localparam logic [15:0] COMP_LP_64 = 16'd120;
    localparam logic [15:0] COMP_LP_128 = 16'd162;
    localparam logic [15:0] COMP_LP_256 = 16'd224;
    localparam logic [15:0] FILT_NP_64 = 16'd3504;
    localparam logic [15:0] FILT_NP_128 = 16'd6960;
    localparam logic [15:0] FILT_NP_256 = 16'd13608;
    localparam logic [15:0] FILT_LP_64 = 16'd3552;
    localparam logic [15:0] FILT_LP_128 = 16'd7008;
    localparam logic [15:0] FILT_LP_256 = 16'd13920;
    localparam logic [4:0] COARSE_GD = 5'h1C;
    localparam logic [4:0] COARSE_GD_LP64 = 5'h1D;

    // ------------------------------------------------------------
    // per-mode lookups
    // ------------------------------------------------------------
    function automatic logic [15:0] sync_offset(input logic lp, input logic [1:0] d);
        case (d)
            DEC_64: sync_offset = lp ? OFFSET_LP_64 : OFFSET_NP_64;
            DEC_128: sync_offset = lp ? OFFSET_LP_128 : OFFSET_NP_128;
            default: sync_offset = lp ? OFFSET_LP_256 : OFFSET_NP_256;
        endcase
    endfunction : sync_offset

    function automatic logic [15:0] fine_delay(input logic lp, input logic [1:0] d);
        case (d)
            DEC_64: fine_delay = lp ? COMP_LP_64 + FILT_LP_64 : COMP_NP_64 + FILT_NP_64;
            DEC_128: fine_delay = lp ? COMP_LP_128 + FILT_LP_128 : COMP_NP_128 + FILT_NP_128;
            default: fine_delay = lp ? COMP_LP_256 + FILT_LP_256 : COMP_NP_256 + FILT_NP_256;
        endcase
    endfunction : fine_delay

endpackage : dcf_pkg

// [dcf_strm_if.sv]
`timescale 1ns/1ps
interface dcf_strm_if #(parameter int W = 12);
    logic valid;
    logic signed [W-1:0] data;
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface : dcf_strm_if

// [dcf_stage.sv]
`timescale 1ns/1ps
module dcf_stage #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] log2_ratio,
    dcf_strm_if.snk in_s,
    dcf_strm_if.src out_s
);
    // ------------------------------------------------------------
    // accumulate-and-dump decimator
    // ------------------------------------------------------------
    logic [4:0] cnt_r;
    logic signed [W-1:0] acc_r;
    logic [4:0] limit;
    logic last;

    assign limit = 5'((6'h01 << log2_ratio) - 6'h01);
    assign last = (cnt_r == limit);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 5'h00;
        end else if (in_s.valid) begin
            cnt_r <= last ? 5'h00 : 5'(cnt_r + 5'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r <= '0;
        end else if (in_s.valid) begin
            acc_r <= last ? '0 : W'(acc_r + in_s.data);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_s.valid <= 1'b0;
            out_s.data <= '0;
        end else begin
            out_s.valid <= in_s.valid && last;
            if (in_s.valid && last) begin
                out_s.data <= W'(acc_r + in_s.data);
            end
        end
    end

    a_stage_dump: assert property (@(posedge clk) disable iff (rst)
        out_s.valid |-> $past(in_s.valid) && $past(cnt_r) == limit)
        else $error("stage dumped before its ratio was reached");

endmodule : dcf_stage

// [dcf_top.sv]
`timescale 1ns/1ps
// How it works
// - modulator samples run at clock/2 normally, clock/4 in low power.
// - one modulator word enters the filter chain per sample period.
// - first stage decimates modulator words by four.
// - second stage decimates by eight to thirty-two per overall ratio, half that in low power.
// - third stage always decimates by two.
// - ratios 64, 128, 256; output rate is clock/2 over the ratio.
// - restart input is sampled only on clock rising edges.
// - restart rising edge realigns filtering from that edge.
// - normal power first strobe fall at 87, 141 or 252 clocks.
// - each output word marked by strobe falling edge; early words mix.
// - normal power settled flag after 7128, 13966 or 27901 clocks.
// - normal power filter delays 3504/6960/13608 plus computation 80/113/443.
// - normal power fine group delay 3584, 7073 or 14051 clocks.
// - coarse group delay 28 word periods, 29 at 64 low power.
// - output words are twos complement.
// - low power first strobe fall at 113, 167 or 277 clocks.
// - low power settled flag after 7282, 14248 or 27926 clocks.
// - low power fine group delay 3672, 7170 or 14144 clocks.
module dcf_top #(
    parameter int MOD_W = 4,
    parameter int OUT_W = 24,
    parameter int SETTLE_NP_64 = 7128,
    parameter int SETTLE_NP_128 = 13966,
    parameter int SETTLE_NP_256 = 27901,
    parameter int SETTLE_LP_64 = 7282,
    parameter int SETTLE_LP_128 = 14248,
    parameter int SETTLE_LP_256 = 27926
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic low_power,
    input wire logic [1:0] dec_sel,
    input wire logic [MOD_W-1:0] mod_word,
    output logic modulator_sample_clock,
    output logic output_frame_strobe,
    output logic [OUT_W-1:0] conv_word,
    output logic filter_settled_flag,
    output logic [4:0] coarse_group_delay,
    output logic [15:0] fine_group_delay
);
    localparam int ACC_W = MOD_W + 8;

    typedef enum logic [1:0] {
        PH_ALIGN = 2'b01,
        PH_FRAME = 2'b10
    } dcf_phase_e;

    if (MOD_W < 1 || OUT_W < ACC_W + 1 || SETTLE_LP_256 > 65535 || SETTLE_NP_256 > 65535) begin : g_bad
        $error("dcf_top: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // restart detection and mode decode
    // ------------------------------------------------------------
    logic restart_q_r;
    logic restart_edge;
    logic realign;
    logic [1:0] dec_idx;
    logic [1:0] div_last;
    logic [2:0] st2_log2;
    logic [3:0] osr_log2;

    always_ff @(posedge core_clk) begin
        restart_q_r <= rst ? 1'b0 : restart;
    end

    assign restart_edge = restart && !restart_q_r;
    assign realign = rst || restart_edge;
    assign dec_idx = (dec_sel > dcf_pkg::DEC_256) ? dcf_pkg::DEC_64 : dec_sel;
    assign div_last = low_power ? dcf_pkg::DIV_LOW_LAST : dcf_pkg::DIV_NORMAL_LAST;
    assign st2_log2 = 3'(dcf_pkg::ST2_LOG2_BASE + 3'(dec_idx) - 3'(low_power));
    assign osr_log2 = 4'(4'(dcf_pkg::OSR_LOG2_BASE) + 4'(dec_idx) - 4'(low_power));

    // ------------------------------------------------------------
    // modulator sample rate
    // ------------------------------------------------------------
    logic [1:0] div_r;
    logic samp_en;

    assign samp_en = (div_r == 2'h0);

    always_ff @(posedge core_clk) begin
        if (realign) begin
            div_r <= 2'h0;
        end else begin
            div_r <= (div_r == div_last) ? 2'h0 : 2'(div_r + 2'h1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (realign) begin
            modulator_sample_clock <= 1'b1;
        end else begin
            modulator_sample_clock <= (div_r == div_last);
        end
    end

    // ------------------------------------------------------------
    // three decimating stages
    // ------------------------------------------------------------
    dcf_strm_if #(.W(ACC_W)) s0 ();
    dcf_strm_if #(.W(ACC_W)) s1 ();
    dcf_strm_if #(.W(ACC_W)) s2 ();
    dcf_strm_if #(.W(ACC_W)) s3 ();

    assign s0.valid = samp_en;
    assign s0.data = ACC_W'($signed(mod_word));

    dcf_stage #(.W(ACC_W)) u_st1 (
        .clk(core_clk), .rst(realign), .log2_ratio(dcf_pkg::ST1_LOG2), .in_s(s0), .out_s(s1));
    dcf_stage #(.W(ACC_W)) u_st2 (
        .clk(core_clk), .rst(realign), .log2_ratio(st2_log2), .in_s(s1), .out_s(s2));
    dcf_stage #(.W(ACC_W)) u_st3 (
        .clk(core_clk), .rst(realign), .log2_ratio(dcf_pkg::ST3_LOG2), .in_s(s2), .out_s(s3));

    // ------------------------------------------------------------
    // frame timing since restart
    // ------------------------------------------------------------
    dcf_phase_e phase_r;
    logic [15:0] cyc_r;
    logic [15:0] frm_r;
    logic [15:0] offset;
    logic [15:0] period;
    logic [15:0] settle;
    logic fso_fall;

    assign offset = dcf_pkg::sync_offset(low_power, dec_idx);
    assign period = 16'(dcf_pkg::ODR_PERIOD_64 << dec_idx);

    always_comb begin
        case ({low_power, dec_idx})
            3'b000: settle = 16'(SETTLE_NP_64);
            3'b001: settle = 16'(SETTLE_NP_128);
            3'b010: settle = 16'(SETTLE_NP_256);
            3'b100: settle = 16'(SETTLE_LP_64);
            3'b101: settle = 16'(SETTLE_LP_128);
            default: settle = 16'(SETTLE_LP_256);
        endcase
    end

    always_comb begin
        case (phase_r)
            PH_ALIGN: fso_fall = (cyc_r == 16'(offset - 16'h0001));
            PH_FRAME: fso_fall = (frm_r == 16'(period - 16'h0001));
            default: fso_fall = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (realign) begin
            cyc_r <= 16'h0000;
        end else if (cyc_r != 16'hFFFF) begin
            cyc_r <= 16'(cyc_r + 16'h0001);
        end
    end

    always_ff @(posedge core_clk) begin
        if (realign) begin
            phase_r <= PH_ALIGN;
        end else if (fso_fall) begin
            phase_r <= PH_FRAME;
        end
    end

    always_ff @(posedge core_clk) begin
        if (realign || fso_fall) begin
            frm_r <= 16'h0000;
        end else if (phase_r == PH_FRAME) begin
            frm_r <= 16'(frm_r + 16'h0001);
        end
    end

    always_ff @(posedge core_clk) begin
        output_frame_strobe <= realign ? 1'b1 : !fso_fall;
    end

    // ------------------------------------------------------------
    // output word, settled flag, delays
    // ------------------------------------------------------------
    logic signed [ACC_W-1:0] word_r;
    logic signed [OUT_W-1:0] word_ext;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            word_r <= '0;
        end else if (s3.valid) begin
            word_r <= s3.data;
        end
    end

    assign word_ext = OUT_W'(word_r);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            conv_word <= '0;
        end else if (fso_fall) begin
            conv_word <= OUT_W'(word_ext <<< (OUT_W - ACC_W + int'(dcf_pkg::OSR_LOG2_MAX - osr_log2)));
        end
    end

    always_ff @(posedge core_clk) begin
        if (realign) begin
            filter_settled_flag <= 1'b0;
        end else if (cyc_r == 16'(settle - 16'h0001)) begin
            filter_settled_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            coarse_group_delay <= dcf_pkg::COARSE_GD;
            fine_group_delay <= 16'h0000;
        end else begin
            coarse_group_delay <= (low_power && dec_idx == dcf_pkg::DEC_64) ?
                dcf_pkg::COARSE_GD_LP64 : dcf_pkg::COARSE_GD;
            fine_group_delay <= dcf_pkg::fine_delay(low_power, dec_idx);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_samp_normal: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        (!low_power && samp_en) |=> !samp_en ##1 samp_en)
        else $error("normal power sample spacing wrong");
    a_samp_low: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        (low_power && samp_en) |=> !samp_en [*3] ##1 samp_en)
        else $error("low power sample spacing wrong");
    a_first_strobe: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        (phase_r == PH_ALIGN && cyc_r == 16'(offset - 16'h0001)) |=> !output_frame_strobe && cyc_r == offset)
        else $error("first strobe not at restart offset");
    a_strobe_pulse: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        $fell(output_frame_strobe) |=> output_frame_strobe)
        else $error("strobe low longer than one cycle");
    a_frame_bound: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        frm_r < period)
        else $error("frame counter ran past word period");
    a_settle_time: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        (cyc_r == 16'(settle - 16'h0001)) |=> filter_settled_flag)
        else $error("settled flag late");
    a_settle_early: assert property (@(posedge core_clk) disable iff (rst || restart_edge)
        (cyc_r < settle) |-> !filter_settled_flag)
        else $error("settled flag early");
    a_restart_clear: assert property (@(posedge core_clk) disable iff (rst)
        restart_edge |=> !filter_settled_flag && cyc_r == 16'h0000 && output_frame_strobe)
        else $error("restart did not realign");

endmodule : dcf_top

// [dcf_host.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: takes a word on each falling edge of the strobe
// ------------------------------------------------------------
module dcf_host (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic output_frame_strobe,
    input wire logic [23:0] conv_word,
    output logic [31:0] gap,
    output logic [23:0] word
);
    logic strobe_r;
    logic [31:0] since_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobe_r <= 1'b1;
            since_r <= 32'h0;
            gap <= 32'h0;
            word <= 24'h0;
        end else begin
            strobe_r <= output_frame_strobe;
            since_r <= since_r + 32'h1;
            if (strobe_r && !output_frame_strobe) begin
                word <= conv_word;
                gap <= since_r;
                since_r <= 32'h1;
            end
        end
    end
endmodule : dcf_host

// [decimation_filter_sync_timing_test.sv]
`timescale 1ns/1ps
module decimation_filter_sync_timing_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic restart = 1'b0;
    logic low_power = 1'b0;
    logic [1:0] dec_sel = 2'h0;
    logic [3:0] mod_word = 4'h0;
    logic modulator_sample_clock;
    logic output_frame_strobe;
    logic filter_settled_flag;
    logic [23:0] conv_word;
    logic [4:0] coarse_group_delay;
    logic [15:0] fine_group_delay;
    logic [31:0] host_gap;
    logic [23:0] host_word;
    int n_errors = 0;
    int checks_done = 0;

    always #25 core_clk = ~core_clk;

    dcf_top #(.SETTLE_NP_128(400), .SETTLE_NP_256(600),
              .SETTLE_LP_64(320), .SETTLE_LP_128(420), .SETTLE_LP_256(700)) uut (
        .core_clk(core_clk), .rst(rst), .restart(restart), .low_power(low_power),
        .dec_sel(dec_sel), .mod_word(mod_word), .modulator_sample_clock(modulator_sample_clock),
        .output_frame_strobe(output_frame_strobe), .conv_word(conv_word),
        .filter_settled_flag(filter_settled_flag), .coarse_group_delay(coarse_group_delay),
        .fine_group_delay(fine_group_delay)
    );

    dcf_host host (
        .core_clk(core_clk), .rst(rst), .output_frame_strobe(output_frame_strobe),
        .conv_word(conv_word), .gap(host_gap), .word(host_word)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    task automatic reset_values;
        repeat (10) @(negedge core_clk);
        check("strobe_reset", 32'(output_frame_strobe), 32'h1);
        check("flag_reset", 32'(filter_settled_flag), 32'h0);
        rst = 1'b0;
    endtask : reset_values

    // ------------------------------------------------------------
    // restart in one mode, then measure timing and words
    // ------------------------------------------------------------
    task automatic run_mode(input logic lp, input logic [1:0] dsel, input logic [3:0] mw);
        int ratio, n, s, f, k, first, settle, highs;
        logic [1:0] d;
        d = (dsel == 2'h3) ? 2'h0 : dsel;
        ratio = 64 << d;
        case ({lp, d})
            3'b000: begin n = 87; s = 7128; f = 3584; end
            3'b001: begin n = 141; s = 400; f = 7073; end
            3'b010: begin n = 252; s = 600; f = 14051; end
            3'b100: begin n = 113; s = 320; f = 3672; end
            3'b101: begin n = 167; s = 420; f = 7170; end
            default: begin n = 277; s = 700; f = 14144; end
        endcase
        @(negedge core_clk);
        restart = 1'b0;
        // selections change together with the restart rise, so no edge sees a stale count
        @(negedge core_clk);
        low_power = lp;
        dec_sel = dsel;
        mod_word = mw;
        restart = 1'b1;
        @(posedge core_clk);
        #1;
        check("flag_cleared", 32'(filter_settled_flag), 32'h0);
        first = 0;
        settle = 0;
        highs = 0;
        // restart stays high throughout: only its edge may count
        for (k = 1; k <= s + 2 * ratio + 2; k++) begin
            @(posedge core_clk);
            #1;
            if (first == 0 && output_frame_strobe === 1'b0) first = k;
            if (settle == 0 && filter_settled_flag === 1'b1) settle = k;
            if (k <= 64 && modulator_sample_clock === 1'b1) highs++;
        end
        check("sample_count", 32'(highs), lp ? 32'd16 : 32'd32);
        check("first_strobe", 32'(first), 32'(n));
        check("settle_time", 32'(settle), 32'(s));
        check("frame_gap", host_gap, 32'(2 * ratio));
        check("coarse_delay", 32'(coarse_group_delay), (lp && d == 2'h0) ? 32'd29 : 32'd28);
        check("fine_delay", 32'(fine_group_delay), 32'(f));
        if (mw == 4'h0)
            check("zero_word", 32'(host_word), 32'h0);
        else
            check("word_sign", 32'(host_word[23]), 32'(mw[3]));
        @(negedge core_clk);
        restart = 1'b0;
    endtask : run_mode

    initial begin
        reset_values();
        run_mode(1'b0, 2'h0, 4'h0);
        run_mode(1'b0, 2'h1, 4'h7);
        run_mode(1'b0, 2'h2, 4'h8);
        run_mode(1'b1, 2'h0, 4'h7);
        run_mode(1'b1, 2'h1, 4'h8);
        run_mode(1'b1, 2'h2, 4'h0);
        run_mode(1'b0, 2'h3, 4'h8);
        stop_test();
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end
endmodule : decimation_filter_sync_timing_test
